// ---- core/tml_encoder.sv ----
// Three-lane transition-minimised encoder with bit serialisers.
// Assumes clk_i oversamples the pixel clock; all pixel-side inputs are asynchronous.
//
// How it works
// - With data enable high, each byte becomes a transition-minimised 10-bit character, DC-balanced over the stream by running disparity.
// - Every one of 256 byte values yields its own in-band character.
// - First eight bits of an in-band character have at most three transitions.
// - Alphabet per lane is 460 in-band plus 4 out-of-band characters.
// - Lane carries 8 data bits, enable state implied by character class, 2 controls.
// - With data enable low, data ignored; control pair picks one special character.
// - Special characters d0..d9: 0010101011, 1101010100, 0010101010, 1101010101.
// - Green lane encodes recovery-loop sync and general control 1 the same way.
// - Held-low data enable with unchanged controls repeats the same special character every period.
// - One ten-bit character loaded per pixel clock period; a lane sends one bit per clk_i cycle until the next load.
// - Blue lane carries syncs, green recovery sync and ctrl 1, red ctrls 2 and 3.
// - Link clock lane sends the pixel clock level as resynchronised and filtered on clk_i, four clk_i stages behind the pin.
`timescale 1ns/10ps
module tml_encoder
  import tml_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pixel_input_clock_i,
  input wire logic data_enable_i,
  input wire logic [23:0] pixel_data_i,
  input wire logic hsync_i,
  input wire logic vsync_i,
  input wire logic pll_sync_i,
  input wire logic general_ctrl_1_i,
  input wire logic general_ctrl_2_i,
  input wire logic stereo_sync_ctrl_i,
  output logic [9:0] char_blue_o,
  output logic [9:0] char_green_o,
  output logic [9:0] char_red_o,
  output logic char_valid_o,
  output logic lane_blue_o,
  output logic lane_green_o,
  output logic lane_red_o,
  output logic lane_link_clock_o
);

  function automatic logic [9:0] special_char(input logic [1:0] pair);
    logic [9:0] c;
    c = TML_CHAR_C00;
    unique case (pair)
      2'b00: c = TML_CHAR_C00;
      2'b01: c = TML_CHAR_C10;
      2'b10: c = TML_CHAR_C01;
      2'b11: c = TML_CHAR_C11;
    endcase
    return c;
  endfunction

  function automatic int ones8(input logic [7:0] v);
    int n;
    n = 0;
    for (int i = 0; i < 8; i++) begin
      n = n + int'(v[i]);
    end
    return n;
  endfunction

  // Returns {new disparity, character}
  // distinct code per byte
  function automatic logic [14:0] encode(input logic [7:0] d, input logic [4:0] disp);
    logic [8:0] qm;
    logic [9:0] q;
    logic use_xnor;
    int n1;
    int n0;
    int cnt;
    n1 = ones8(d);
    use_xnor = (n1 > 4) || (n1 == 4 && !d[0]);
    qm = 9'h000;
    qm[0] = d[0];
    for (int i = 1; i < 8; i++) begin
      qm[i] = use_xnor ? ~(qm[i-1] ^ d[i]) : (qm[i-1] ^ d[i]);
    end
    qm[8] = ~use_xnor;
    n1 = ones8(qm[7:0]);
    n0 = 8 - n1;
    cnt = int'(signed'(disp));
    if (cnt == 0 || n1 == n0) begin
      q = {~qm[8], qm[8], qm[8] ? qm[7:0] : ~qm[7:0]};
      cnt = qm[8] ? cnt + n1 - n0 : cnt + n0 - n1;
    end else if ((cnt > 0 && n1 > n0) || (cnt < 0 && n0 > n1)) begin
      q = {1'b1, qm[8], ~qm[7:0]};
      cnt = cnt + 2 * int'(qm[8]) + n0 - n1;
    end else begin
      q = {1'b0, qm[8], qm[7:0]};
      cnt = cnt - 2 * int'(!qm[8]) + n1 - n0;
    end
    return {cnt[4:0], q};
  endfunction

  tml_st_t st_ff;
  tml_st_t nxt_st;
  logic [31:0] pins;
  logic [14:0] enc_res [3];

  assign pins = {stereo_sync_ctrl_i, general_ctrl_2_i, general_ctrl_1_i, pll_sync_i,
                 vsync_i, hsync_i, pixel_data_i, data_enable_i, pixel_input_clock_i};

  always_comb begin
    logic clk_stable;
    logic fall;
    logic de_s;
    clk_stable = 1'b0;
    fall = 1'b0;
    de_s = 1'b0;
    nxt_st = st_ff;
    nxt_st.s1 = pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    clk_stable = st_ff.s2[TML_POS_PCLK] == st_ff.s3[TML_POS_PCLK];
    if (clk_stable) begin
      nxt_st.clk_lvl = st_ff.s3[TML_POS_PCLK];
    end
    // Sample mid-period on the falling edge, where source data is settled
    fall = clk_stable && st_ff.clk_lvl && !st_ff.s3[TML_POS_PCLK];
    de_s = st_ff.s3[TML_POS_DE];
    nxt_st.ld = fall;
    for (int l = 0; l < TML_LANES; l++) begin
      nxt_st.sh[l] = {1'b0, st_ff.sh[l][9:1]};
      enc_res[l] = encode(st_ff.s3[TML_POS_DATA + 8*l +: 8], st_ff.disp[l]);
    end
    if (fall) begin
      nxt_st.de = de_s;
      if (!de_s) begin
        nxt_st.ctrl = st_ff.s3[TML_POS_CTRL +: 6];
      end
      // lane l takes data byte l and control pair l
      for (int l = 0; l < TML_LANES; l++) begin
        if (de_s) begin
          nxt_st.chr[l] = enc_res[l][9:0];
          nxt_st.disp[l] = enc_res[l][14:10];
        end else begin
          // special character from the control pair
          nxt_st.chr[l] = special_char(st_ff.s3[TML_POS_CTRL + 2*l +: 2]);
          nxt_st.disp[l] = TML_DISP_RST;
        end
        // one character loaded per pixel period
        nxt_st.sh[l] = nxt_st.chr[l];
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff.s1 <= TML_IN_RST;
      st_ff.s2 <= TML_IN_RST;
      st_ff.s3 <= TML_IN_RST;
      st_ff.clk_lvl <= 1'b0;
      st_ff.de <= 1'b0;
      st_ff.ctrl <= 6'h00;
      st_ff.ld <= 1'b0;
      for (int l = 0; l < TML_LANES; l++) begin
        st_ff.chr[l] <= TML_CHAR_RST;
        st_ff.disp[l] <= TML_DISP_RST;
        st_ff.sh[l] <= TML_CHAR_RST;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign char_blue_o = st_ff.chr[0];
  assign char_green_o = st_ff.chr[1];
  assign char_red_o = st_ff.chr[2];
  assign char_valid_o = st_ff.ld;
  assign lane_blue_o = st_ff.sh[0][0];
  assign lane_green_o = st_ff.sh[1][0];
  assign lane_red_o = st_ff.sh[2][0];
  // link clock lane follows the pixel clock
  assign lane_link_clock_o = st_ff.clk_lvl;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  function automatic logic is_special(input logic [9:0] c);
    return c == TML_CHAR_C00 || c == TML_CHAR_C10 || c == TML_CHAR_C01 || c == TML_CHAR_C11;
  endfunction

  function automatic int edges8(input logic [9:0] c);
    return $countones(c[6:0] ^ c[7:1]);
  endfunction

  a_blank_char: assert property (st_ff.ld && !st_ff.de |->
    st_ff.chr[0] == special_char(st_ff.ctrl[1:0]) && st_ff.chr[2] == special_char(st_ff.ctrl[5:4]))
    else $error("blank character does not match controls");
  a_green_pair: assert property (st_ff.ld && !st_ff.de |->
    st_ff.chr[1] == special_char(st_ff.ctrl[3:2]))
    else $error("green lane special character wrong");
  a_inband_class: assert property (st_ff.ld && st_ff.de |->
    !is_special(st_ff.chr[0]) && !is_special(st_ff.chr[1]) && !is_special(st_ff.chr[2]))
    else $error("in-band character collides with a special one");
  a_disp_clear: assert property (st_ff.ld && !st_ff.de |-> st_ff.disp == '0)
    else $error("disparity not cleared in blanking");
  a_ctrl_hold: assert property (st_ff.de && $past(st_ff.de) |-> $stable(st_ff.ctrl))
    else $error("controls changed during active data");
  a_blank_repeat: assert property (st_ff.ld && !st_ff.de && !$past(st_ff.de) && $stable(st_ff.ctrl) |->
    $stable(st_ff.chr))
    else $error("blank character not repeated");
  a_inband_edges: assert property (st_ff.ld && st_ff.de |->
    edges8(st_ff.chr[0]) <= 3 && edges8(st_ff.chr[1]) <= 3 && edges8(st_ff.chr[2]) <= 3)
    else $error("in-band character has too many transitions");
  a_serial_order: assert property (st_ff.ld ##1 !st_ff.ld |->
    lane_blue_o == $past(st_ff.chr[0][1]) && lane_red_o == $past(st_ff.chr[2][1]))
    else $error("serial bit order wrong");
  a_link_clock: assert property (st_ff.ld == $fell(lane_link_clock_o))
    else $error("character load not aligned to link clock fall");

  c_active: cover property (st_ff.ld && st_ff.de);
  c_blank: cover property (st_ff.ld && !st_ff.de);
  c_blank_repeat: cover property (st_ff.ld && !st_ff.de && !$past(st_ff.de) && $stable(st_ff.ctrl));
  c_to_active: cover property (st_ff.ld && !st_ff.de ##[1:40] st_ff.ld && st_ff.de);

endmodule

// ---- common/tml_pkg.sv ----
// Package for the transition-minimised link encoder: input bit layout,
// out-of-band characters and the state record.
// Assumes a single system clock that oversamples the pixel clock.
package tml_pkg;

  localparam int TML_LANES = 3;
  localparam int TML_CHAR_W = 10;
  localparam int TML_DISP_W = 5;
  localparam int TML_IN_W = 32;

  // Positions in the sampled input vector
  localparam int TML_POS_PCLK = 0;
  localparam int TML_POS_DE = 1;
  localparam int TML_POS_DATA = 2;
  localparam int TML_POS_CTRL = 26;

  // Out-of-band characters, bit 0 is d0 (first on the wire)
  localparam logic [9:0] TML_CHAR_C00 = 10'h354;
  localparam logic [9:0] TML_CHAR_C10 = 10'h0AB;
  localparam logic [9:0] TML_CHAR_C01 = 10'h154;
  localparam logic [9:0] TML_CHAR_C11 = 10'h2AB;

  localparam logic [31:0] TML_IN_RST = 32'h0000_0000;
  localparam logic [9:0] TML_CHAR_RST = 10'h354;
  localparam logic [4:0] TML_DISP_RST = 5'h00;

  typedef struct packed {
    logic [31:0] s1;
    logic [31:0] s2;
    logic [31:0] s3;
    logic clk_lvl;
    logic de;
    logic [5:0] ctrl;
    logic ld;
    logic [2:0][9:0] chr;
    logic [2:0][4:0] disp;
    logic [2:0][9:0] sh;
  } tml_st_t;

endpackage

// ---- sim/tml_pix_src.sv ----
// Pixel source model: free-running pixel clock and the pixel-side inputs.
// Assumes clk_i is the 20 MHz bench clock; pixel clock is 400 ns.
`timescale 1ns/10ps
module tml_pix_src (
  input wire logic clk_i,
  input wire logic de_i,
  input wire logic [23:0] data_i,
  input wire logic [5:0] ctrl_i,
  output logic pclk_o,
  output logic de_o,
  output logic [23:0] data_o,
  output logic [5:0] ctrl_o
);
  logic [1:0] ph = 2'h0;
  initial begin
    pclk_o = 1'b0;
    de_o = 1'b0;
    data_o = 24'h000000;
    ctrl_o = 6'h00;
  end
  always @(negedge clk_i) begin
    ph <= ph + 2'h1;
    if (ph == 2'h3) begin
      pclk_o <= ~pclk_o;
      if (!pclk_o) begin
        de_o <= de_i;
        data_o <= de_i ? data_i : ~data_o;
        if (!de_i) begin
          ctrl_o <= ctrl_i;
        end
      end
    end
  end
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the three-lane encoder.
// Assumes the pixel source model drives all pixel-side inputs.
`timescale 1ns/10ps
module testbench;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic de = 1'b0;
  logic [23:0] data = 24'h000000;
  logic [5:0] ctrl = 6'h00;
  logic pclk, s_de, cv, lb, lg, lr, lc;
  logic [23:0] s_data;
  logic [5:0] s_ctrl;
  logic [9:0] cb, cg, cr;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [9:0] spec [4] = '{10'h354, 10'h0AB, 10'h154, 10'h2AB};
  always #25 clk_i = ~clk_i;
  tml_pix_src u_tml_pix_src (.clk_i(clk_i), .de_i(de), .data_i(data), .ctrl_i(ctrl),
    .pclk_o(pclk), .de_o(s_de), .data_o(s_data), .ctrl_o(s_ctrl));
  tml_encoder u_tml_encoder (.clk_i(clk_i), .nrst_i(nrst_i), .pixel_input_clock_i(pclk),
    .data_enable_i(s_de), .pixel_data_i(s_data), .hsync_i(s_ctrl[0]), .vsync_i(s_ctrl[1]),
    .pll_sync_i(s_ctrl[2]), .general_ctrl_1_i(s_ctrl[3]), .general_ctrl_2_i(s_ctrl[4]),
    .stereo_sync_ctrl_i(s_ctrl[5]), .char_blue_o(cb), .char_green_o(cg), .char_red_o(cr),
    .char_valid_o(cv), .lane_blue_o(lb), .lane_green_o(lg), .lane_red_o(lr), .lane_link_clock_o(lc));
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_valid(output int gap);
    gap = 0;
    do begin
      @(negedge clk_i);
      gap++;
      if (gap > 40) begin
        n_mismatch++;
        close_out();
      end
    end while (cv !== 1'b1);
  endtask
  function automatic logic [7:0] dec(input logic [9:0] c);
    logic [7:0] x, o;
    x = c[9] ? ~c[7:0] : c[7:0];
    o[0] = x[0];
    for (int i = 1; i < 8; i++) o[i] = c[8] ? x[i] ^ x[i-1] : ~(x[i] ^ x[i-1]);
    return o;
  endfunction
  function automatic logic [1:0] ctrl_of(input logic [9:0] c);
    logic [1:0] r;
    r = 2'h0;
    for (int j = 0; j < 4; j++) begin
      if (c == spec[j]) r = 2'(j);
    end
    return r;
  endfunction
  task automatic t_special();
    int g;
    for (int k = 0; k < 4; k++) begin
      ctrl <= {2'((k + 2) % 4), 2'((k + 1) % 4), 2'(k)};
      de <= 1'b0;
      wait_valid(g);
      wait_valid(g);
      check(cb, spec[k]);
      check(cg, spec[(k + 1) % 4]);
      check(cr, spec[(k + 2) % 4]);
      check({8'h00, ctrl_of(cr)}, {8'h00, 2'((k + 2) % 4)});
      wait_valid(g);
      check(cb, spec[k]);
      check(10'(g), 10'h008);
      for (int i = 0; i < 8; i++) begin
        check({7'h00, lb, lg, lr}, {7'h00, spec[k][i], spec[(k + 1) % 4][i], spec[(k + 2) % 4][i]});
        @(negedge clk_i);
      end
    end
  endtask
  task automatic t_inband();
    int g, rd;
    logic [7:0] v [5] = '{8'h00, 8'hFF, 8'h5A, 8'h81, 8'h10};
    rd = 0;
    foreach (v[i]) begin
      data <= {v[i] ^ 8'h3C, v[i] ^ 8'hC3, v[i]};
      de <= 1'b1;
      wait_valid(g);
      if (i > 0) rd += 2 * $countones(cb) - 10;
      wait_valid(g);
      check({2'h0, dec(cb)}, {2'h0, v[i]});
      check({2'h0, dec(cg)}, {2'h0, v[i] ^ 8'hC3});
      check({2'h0, dec(cr)}, {2'h0, v[i] ^ 8'h3C});
      check({9'h000, cb == 10'h354 || cb == 10'h0AB || cb == 10'h154 || cb == 10'h2AB}, 10'h000);
      rd += 2 * $countones(cb) - 10;
      check({9'h000, rd <= 10 && rd >= -10}, 10'h001);
      check({9'h000, $countones(cb[6:0] ^ cb[7:1]) <= 3}, 10'h001);
    end
    de <= 1'b0;
    ctrl <= 6'h3F;
    wait_valid(g);
    wait_valid(g);
    check(cb, spec[3]);
    check(cg, spec[3]);
    check(cr, spec[3]);
  endtask
  task automatic t_link();
    int n;
    logic p;
    n = 0;
    p = lc;
    repeat (80) begin
      @(negedge clk_i);
      if (lc !== p) n++;
      p = lc;
    end
    check({9'h000, n >= 19 && n <= 21}, 10'h001);
  endtask
  initial begin
    repeat (6) @(negedge clk_i);
    check({cb[9:0]}, spec[0]);
    check({8'h00, cv, lc}, 10'h000);
    nrst_i <= 1'b1;
    t_special();
    t_inband();
    t_link();
    close_out();
  end
endmodule
